// File: gxh_dev_model.sv
// Behavioural expander device on the two-wire bus.
`default_nettype none
module gxh_dev_model (
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [2:0] i_strap,
  input  wire logic [7:0] i_ext,
  output logic            o_sda_oe,
  output logic      [7:0] o_pins,
  output logic            o_int_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lat = 8'hff, inv = 8'h00, dir = 8'hff, cmd = 8'h00, sh = 8'h00, tx = 8'h00;
  // Port levels taken at the last read of the input register; the interrupt compares against them.
  logic [7:0] snap = 8'h00;
  logic [3:0] bc = 4'h0;
  logic [2:0] st = 3'h0;
  logic       rd = 1'b0, mnak = 1'b0;
  initial o_sda_oe = 1'b0;
  assign o_pins = (dir & i_ext) | (~dir & lat);
  // Output pins are masked off, so only an input that moved can pull the line low.
  assign o_int_n = !(|((i_ext ^ snap) & dir));
  always @(posedge i_rst) begin
    {lat, inv, dir} = 24'hff_00ff;
    snap = i_ext;
    st = 0;
    o_sda_oe = 0;
  end
  always @(negedge i_sda) if (i_scl) begin
    st = 1;
    bc = 0;
  end
  always @(posedge i_sda) if (i_scl) st = 0;
  always @(posedge i_scl) if (st != 0) begin
    if (bc < 8) begin
      sh = {sh[6:0], i_sda};
      bc = bc + 1;
    end else mnak = i_sda;
  end
  // SDA changes only after SCL falls, so the master never sees it move while SCL is high.
  always @(negedge i_scl) if (st != 0) begin
    if (bc == 8) begin
      bc = 9;
      o_sda_oe = 0;
      case (st)
        1: if (sh[7:1] == {4'h7, i_strap}) begin
          rd = sh[0];
          o_sda_oe = 1;
        end else st = 0;
        2: begin
          cmd = sh;
          o_sda_oe = 1;
        end
        3: begin
          o_sda_oe = 1;
          case (cmd[1:0])
            1: lat = sh;
            2: inv = sh;
            3: dir = sh;
            default: ;
          endcase
        end
        default: ;
      endcase
    end else if (bc == 9) begin
      bc = 0;
      o_sda_oe = 0;
      if (st == 1) st = rd ? 4 : 2;
      else if (st == 2) st = 3;
      else if (st == 4 && mnak) st = 0;
      if (st == 4) begin
        if (cmd[1:0] == 0) snap = i_ext;
        tx = cmd[1:0] == 0 ? o_pins ^ (inv & dir) : cmd[1:0] == 1 ? lat : cmd[1:0] == 2 ? inv : dir;
        o_sda_oe = !tx[7];
      end
    end else if (st == 4) o_sda_oe = !tx[7 - bc];
  end
endmodule
`default_nettype wire

// File: gxh_host.sv
// Host controller that reads and writes the expander registers over the two-wire bus.
`default_nettype none
module gxh_host
  import gxh_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_req,
  input  wire logic       i_rd,
  input  wire logic [2:0] i_strap,
  input  wire logic [1:0] i_reg_sel,
  input  wire logic [7:0] i_wdata,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_nack,
  output logic [7:0]      o_rdata,
  input  wire logic       i_scl,
  output logic            o_scl_o,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe
);
  typedef enum logic [3:0] {
    GXH_IDLE, GXH_START, GXH_BIT, GXH_ACK, GXH_NEXT, GXH_RSTART, GXH_STOP, GXH_DONE
  } gxh_state_e;

  // Byte sequence positions within one request.
  typedef enum logic [2:0] {
    GXH_B_WADDR, GXH_B_CMD, GXH_B_WDATA, GXH_B_RADDR, GXH_B_RDATA
  } gxh_byte_e;

  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;

  gxh_sync2 #(.W(2)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   ({i_scl, i_sda}),
    .o_sync    (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  function automatic logic [7:0] addr_byte(input logic [2:0] strap, input logic dir);
    addr_byte = {1'b0, ADDR_FIXED_HI[2:0], strap, dir};
  endfunction

  gxh_state_e state_q, state_d;
  gxh_byte_e  byte_q, byte_d;
  logic [1:0] phase_q, phase_d;
  logic [15:0] tick_q, tick_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic       rd_q, rd_d;
  logic [2:0] strap_q, strap_d;
  logic [1:0] sel_q, sel_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] rdata_q, rdata_d;
  logic       nack_q, nack_d;
  logic       scl_low_q, scl_low_d;
  logic       sda_low_q, sda_low_d;
  logic       step;

  // Each bus bit is four quarter phases; phase 1 raises SCL, phase 3 drops it.
  assign step = (tick_q == 16'(QTR - 1));

  always_comb begin
    state_d   = state_q;
    byte_d    = byte_q;
    phase_d   = phase_q;
    tick_d    = step ? 16'h0000 : tick_q + 16'h0001;
    bit_d     = bit_q;
    shift_d   = shift_q;
    rd_d      = rd_q;
    strap_d   = strap_q;
    sel_d     = sel_q;
    wdata_d   = wdata_q;
    rdata_d   = rdata_q;
    nack_d    = nack_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    case (state_q)
      GXH_IDLE: begin
        tick_d    = 16'h0000;
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
        if (i_req) begin
          rd_d    = i_rd;
          strap_d = i_strap;
          sel_d   = i_reg_sel;
          wdata_d = i_wdata;
          nack_d  = 1'b0;
          phase_d = 2'd0;
          state_d = GXH_START;
        end
      end
      GXH_START, GXH_RSTART: begin
        if (step) begin
          phase_d = phase_q + 2'd1;
          case (phase_q)
            2'd0: sda_low_d = 1'b0;
            2'd1: scl_low_d = 1'b0;
            2'd2: sda_low_d = 1'b1;
            default: begin
              scl_low_d = 1'b1;
              byte_d    = (state_q == GXH_START) ? GXH_B_WADDR : GXH_B_RADDR;
              shift_d   = addr_byte(strap_q, (state_q == GXH_START) ? DIR_WRITE : DIR_READ);
              bit_d     = 3'(BYTE_BITS - 1);
              state_d   = GXH_BIT;
            end
          endcase
        end
      end
      GXH_BIT: begin
        if (step) begin
          phase_d = phase_q + 2'd1;
          case (phase_q)
            // SDA only moves while SCL is low.
            2'd0: sda_low_d = (byte_q == GXH_B_RDATA) ? 1'b0 : ~shift_q[7];
            2'd1: scl_low_d = 1'b0;
            2'd2: if (!scl_s) phase_d = phase_q; // Clock stretching holds the bit.
            default: begin
              scl_low_d = 1'b1;
              shift_d   = {shift_q[6:0], sda_s};
              if (bit_q == 3'd0) begin
                state_d = GXH_ACK;
              end else begin
                bit_d = bit_q - 3'd1;
              end
            end
          endcase
        end
      end
      GXH_ACK: begin
        if (step) begin
          phase_d = phase_q + 2'd1;
          case (phase_q)
            // SDA is released in every ack slot, so the one read data byte gets a NACK.
            2'd0: sda_low_d = 1'b0;
            2'd1: scl_low_d = 1'b0;
            2'd2: begin
              if (!scl_s) phase_d = phase_q;
              else if (byte_q != GXH_B_RDATA && sda_s) nack_d = 1'b1;
            end
            default: begin
              scl_low_d = 1'b1;
              if (byte_q == GXH_B_RDATA) rdata_d = shift_q;
              state_d = GXH_NEXT;
            end
          endcase
        end
      end
      GXH_NEXT: begin
        phase_d = 2'd0;
        bit_d   = 3'(BYTE_BITS - 1);
        if (nack_q || byte_q == GXH_B_RDATA || byte_q == GXH_B_WDATA) begin
          state_d = GXH_STOP;
        end else if (byte_q == GXH_B_WADDR) begin
          byte_d  = GXH_B_CMD;
          shift_d = {6'h00, sel_q};
          state_d = GXH_BIT;
        end else if (byte_q == GXH_B_CMD) begin
          if (rd_q) begin
            state_d = GXH_RSTART;
          end else begin
            byte_d  = GXH_B_WDATA;
            shift_d = wdata_q;
            state_d = GXH_BIT;
          end
        end else begin
          byte_d  = GXH_B_RDATA;
          shift_d = 8'h00;
          state_d = GXH_BIT;
        end
      end
      GXH_STOP: begin
        if (step) begin
          phase_d = phase_q + 2'd1;
          case (phase_q)
            2'd0: sda_low_d = 1'b1;
            2'd1: scl_low_d = 1'b0;
            2'd2: sda_low_d = 1'b0;
            default: state_d = GXH_DONE;
          endcase
        end
      end
      GXH_DONE: state_d = GXH_IDLE;
      default:  state_d = GXH_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q   <= GXH_IDLE;
      byte_q    <= GXH_B_WADDR;
      phase_q   <= 2'd0;
      tick_q    <= 16'h0000;
      bit_q     <= 3'd0;
      shift_q   <= 8'h00;
      rd_q      <= 1'b0;
      strap_q   <= 3'h0;
      sel_q     <= 2'h0;
      wdata_q   <= 8'h00;
      rdata_q   <= 8'h00;
      nack_q    <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      byte_q    <= byte_d;
      phase_q   <= phase_d;
      tick_q    <= tick_d;
      bit_q     <= bit_d;
      shift_q   <= shift_d;
      rd_q      <= rd_d;
      strap_q   <= strap_d;
      sel_q     <= sel_d;
      wdata_q   <= wdata_d;
      rdata_q   <= rdata_d;
      nack_q    <= nack_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
    end
  end

  // Open-drain: only ever pull low, release otherwise.
  assign o_scl_o  = 1'b0;
  assign o_scl_oe = scl_low_q;
  assign o_sda_o  = 1'b0;
  assign o_sda_oe = sda_low_q;
  assign o_busy   = (state_q != GXH_IDLE);
  assign o_done   = (state_q == GXH_DONE);
  assign o_nack   = nack_q;
  assign o_rdata  = rdata_q;
endmodule
`default_nettype wire

// File: gxh_host_sva.sv
// Checker of the host controller's bus framing and handshake.
`default_nettype none
module gxh_host_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_nack,
  input wire logic o_scl_o,
  input wire logic o_scl_oe,
  input wire logic o_sda_o,
  input wire logic o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_idle_released: assert property (!o_busy |-> !o_scl_oe && !o_sda_oe)
    else $error("Bus held while idle.");
  a_open_drain: assert property (o_scl_o == 1'b0 && o_sda_o == 1'b0)
    else $error("Bus driven high.");
  a_req_taken: assert property (i_req && !o_busy |=> o_busy)
    else $error("Request not taken.");
  a_start_first: assert property ($rose(o_busy) |-> !o_sda_oe [*2] ##[1:8] (o_sda_oe && !o_scl_oe))
    else $error("No start condition.");
  a_start_hold: assert property ($rose(o_sda_oe) && !o_scl_oe |-> !o_scl_oe ##1 !o_scl_oe ##[1:3] o_scl_oe)
    else $error("Start not held.");
  a_stop_done: assert property (o_busy && $fell(o_sda_oe) && !o_scl_oe && !$past(o_scl_oe) |-> ##[0:12] o_done)
    else $error("Stop without done.");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("Done too long.");
  a_nack_in_xfer: assert property ($rose(o_nack) |-> o_busy)
    else $error("Nack outside transfer.");
  a_nack_cleared: assert property ($rose(o_busy) |-> !o_nack)
    else $error("Nack not cleared.");
endmodule
bind gxh_host gxh_host_sva u_sva (.i_clk_sys, .i_rst, .i_req, .o_busy, .o_done, .o_nack, .o_scl_o, .o_scl_oe,
  .o_sda_o, .o_sda_oe);
`default_nettype wire

// File: gxh_host_tb_top.sv
// Testbench of the host controller against the device model.
`default_nettype none
module gxh_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gxh_pkg::*;
  logic       clk = 0, rst = 1, req = 0, rd = 0;
  logic [2:0] strap = 0, dstrap = 0;
  logic [1:0] sel = 0;
  logic [7:0] wd = 0, ext = 8'hc3;
  wire logic  busy, done, nack, scl_o, scl_oe, sda_o, sda_oe, dsda_oe, int_n;
  wire logic [7:0] rdata, pins;
  wire logic  scl = ~scl_oe;
  wire logic  sda = ~(sda_oe | dsda_oe);
  int         fails = 0, checks_done = 0;
  gxh_host #(.QTR(2)) DUT (.i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_rd(rd), .i_strap(strap), .i_reg_sel(sel),
    .i_wdata(wd), .o_busy(busy), .o_done(done), .o_nack(nack), .o_rdata(rdata), .i_scl(scl), .o_scl_o(scl_o),
    .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe));
  gxh_dev_model u_dev (.i_rst(rst), .i_scl(scl), .i_sda(sda), .i_strap(dstrap), .i_ext(ext), .o_sda_oe(dsda_oe),
    .o_pins(pins), .o_int_n(int_n));
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      fails++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic results;
    $display("Checks %0d, errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic xfer(input logic r, input logic [2:0] s, input logic [1:0] g, input logic [7:0] d, input logic n,
                      input logic [7:0] e);
    int k = 0;
    @(posedge clk);
    #1 {req, rd, strap, sel, wd} = {1'b1, r, s, g, d};
    @(posedge clk);
    #1 req = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
    chk(k < 3000 && nack === n, "transfer end or nack");
    if (r) chk(rdata === e, "read data");
  endtask
  task automatic t_defaults;
    xfer(1, 0, 1, 0, 0, RST_PIN_DRIVE_LATCH);
    xfer(1, 0, 2, 0, 0, RST_INPUT_INVERT_MASK);
    xfer(1, 0, 3, 0, 0, RST_PIN_DIRECTION_SELECT);
    xfer(1, 0, 0, 0, 0, 8'hc3);
  endtask
  task automatic t_ports;
    xfer(0, 0, 1, 8'h5a, 0, 0);
    xfer(0, 0, 3, 8'h0f, 0, 0);
    chk(pins === 8'h53, "pin drive");
    xfer(1, 0, 1, 0, 0, 8'h5a);
    xfer(0, 0, 2, 8'hff, 0, 0);
    xfer(0, 0, 0, 8'h00, 0, 0);
    xfer(1, 0, 0, 0, 0, 8'h5c);
  endtask
  // Runs with bits 3..0 as inputs and the invert mask all ones, as left by t_ports.
  task automatic t_irq;
    @(posedge clk);
    #1 ext = 8'hc7;
    #1 chk(int_n === 1'b0, "no interrupt on input edge");
    ext = 8'h43;
    #1 chk(int_n === 1'b1, "output pin raised interrupt");
    ext = 8'h47;
    #1 chk(int_n === 1'b0, "no interrupt on input edge");
    ext = 8'h43;
    #1 chk(int_n === 1'b1, "interrupt kept after restore");
    ext = 8'h47;
    #1 chk(int_n === 1'b0, "no interrupt on input edge");
    xfer(1, 0, 0, 0, 0, 8'h58);
    chk(int_n === 1'b1, "interrupt kept after read");
  endtask
  task automatic t_addr;
    for (int s = 0; s < 8; s++) begin
      dstrap = 3'(s);
      xfer(0, 3'(s), 2, 8'(s), 0, 0);
      xfer(0, 3'(s ^ 1), 2, 8'hee, 1, 0);
      xfer(1, 3'(s), 2, 0, 0, 8'(s));
    end
    chk(scl === 1'b1 && sda === 1'b1, "bus not idle");
  endtask
  initial forever #20 clk = ~clk;
  // 35 transfers of under 400 cycles each; the limit leaves a wide margin.
  initial begin
    #2_000_000;
    fails++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    t_defaults();
    t_ports();
    t_irq();
    t_addr();
    results();
  end
endmodule
`default_nettype wire

// File: gxh_pkg.sv
// Package with the constants of the expander host controller.
`default_nettype none
package gxh_pkg;
  localparam logic [3:0] ADDR_FIXED_HI  = 4'h7;
  localparam logic       DIR_READ       = 1'b1;
  localparam logic       DIR_WRITE      = 1'b0;
  localparam logic [7:0] REG_PIN_LEVEL_INPUT      = 8'h00;
  localparam logic [7:0] REG_PIN_DRIVE_LATCH      = 8'h01;
  localparam logic [7:0] REG_INPUT_INVERT_MASK    = 8'h02;
  localparam logic [7:0] REG_PIN_DIRECTION_SELECT = 8'h03;
  localparam logic [7:0] RST_PIN_DRIVE_LATCH      = 8'hff;
  localparam logic [7:0] RST_INPUT_INVERT_MASK    = 8'h00;
  localparam logic [7:0] RST_PIN_DIRECTION_SELECT = 8'hff;
  localparam int         BYTE_BITS      = 8;
  localparam int         CLK_SYS_MHZ    = 25;
  localparam int         SCL_PERIOD_NS  = 10000;
  // A quarter of the bus bit period, rounded down, never below one cycle.
  localparam int         QTR_CYCLES_RAW = (SCL_PERIOD_NS * CLK_SYS_MHZ) / (4 * 1000);
  localparam int         QTR_CYCLES     = (QTR_CYCLES_RAW < 1) ? 1 : QTR_CYCLES_RAW;
endpackage
`default_nettype wire

// File: gxh_sync2.sv
// Two-flop synchroniser for a group of pin inputs.
`default_nettype none
module gxh_sync2 #(
  parameter int W = 2
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  // Pins idle high, so the synchroniser resets to ones and shows no false start.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule
`default_nettype wire
